// [zsl_defs.svh]
`ifndef ZSL_DEFS_SVH
`define ZSL_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ZSL_OFS_CTRL 8'h00
`define ZSL_OFS_TMR 8'h04
`define ZSL_OFS_ONE 8'h08
`define ZSL_OFS_FULL 8'h0C
`define ZSL_OFS_OVER 8'h10
`define ZSL_OFS_STAT 8'h14
`define ZSL_OFS_TRQ 8'h18
`define ZSL_OFS_ISTAT 8'h1C
`define ZSL_OFS_IMASK 8'h20

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ZSL_CTRL_ACT 0
`define ZSL_CTRL_TV 1
`define ZSL_CTRL_EN 2
`define ZSL_CTRL_ARST 3
`define ZSL_STAT_ALM 3
`define ZSL_STAT_ST 8
`define ZSL_EV_DONE 0
`define ZSL_EV_OVER 1
`define ZSL_EV_ALM 2
`define ZSL_EV_ABORT 3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ZSL_CTRL_RST 3'h4
`define ZSL_TMR_RST 16'h0064
`define ZSL_ONE_RST 16'h1000
`define ZSL_FULL_RST 16'h6000
`define ZSL_OVER_RST 16'h7000
`define ZSL_IMASK_RST 4'h0

// ----------------------------------------
// Widths and timing
// ----------------------------------------
`define ZSL_TORQUE_W 16
`define ZSL_CLK_MHZ 100
`define ZSL_TICK_TIME_US 1000
`define ZSL_TICK_CYC (`ZSL_TICK_TIME_US * `ZSL_CLK_MHZ)
`define ZSL_ALARM_DLY_MS 200
`define ZSL_ALARM_DLY_CYC (`ZSL_ALARM_DLY_MS * 1000 * `ZSL_CLK_MHZ)

`endif

// [zsl_pkg.sv]
`default_nettype none
package zsl_pkg;

  // ----------------------------------------
  // Detector states
  // ----------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SETTLE = 5'h02,
    ST_HELD = 5'h04,
    ST_ALM_WAIT = 5'h08,
    ST_ALARM = 5'h10
  } state_type;

  // ----------------------------------------
  // Load outputs
  // ----------------------------------------
  typedef struct packed {
    logic over;
    logic full;
    logic one;
  } load_out_type;

endpackage
`default_nettype wire

// [zero_speed_load_detector.sv]
// Functional notes
// RL1 - Overload action zero: raise overload output, keep running.
// RL2 - Overload action one: raise overload output, then trip into alarm.
// RL3 - Stabilisation timer starts when brake-release indication rises.
// RL4 - At expiry, torque below one-person level raises one-person output.
// RL5 - At expiry, torque between full and overload levels raises full-load.
// RL6 - At expiry, torque above overload level raises overload output.
// RL7 - Load outputs hold until motor current is removed, then clear.
// RL8 - Alarm issues a fixed 0.2 s after overload output rises.
// RL9 - In alarm, current stage is disabled and brake applied.
// RL10 - Detection only during zero speed at start of travel.
// RL11 - Detection inhibited in torque-vector control mode.
// RL12 - One comparison at expiry; torque between one and full gives none.
// RL13 - Re-arm only after end of travel; brake rise restarts timer.
//
// The register offsets and the APB slave port were left to the implementer.
`include "zsl_defs.svh"
`default_nettype none
module zero_speed_load_detector #(
  parameter int TW = `ZSL_TORQUE_W,
  parameter int unsigned TICK_CYC = `ZSL_TICK_CYC,
  parameter int unsigned ALARM_DLY_CYC = `ZSL_ALARM_DLY_CYC
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic [31:0] PRDATA,
  input wire logic BRAKE_RELEASE_INDICATION,
  input wire logic MOTOR_CURRENT_ON,
  input wire logic ZERO_SPEED,
  input wire logic [TW-1:0] MEASURED_TORQUE,
  output logic ONE_PERSON_LOAD_OUTPUT,
  output logic FULL_LOAD_OUTPUT,
  output logic OVERLOAD_OUTPUT,
  output logic OVERLOAD_ALARM,
  output logic CURRENT_STAGE_ENABLE,
  output logic BRAKE_APPLY,
  output logic IRQ
);

  // ----------------------------------------
  // Classification
  // ----------------------------------------
  function automatic zsl_pkg::load_out_type classify(
    input logic [TW-1:0] t,
    input logic [TW-1:0] one,
    input logic [TW-1:0] full,
    input logic [TW-1:0] over
  );
    zsl_pkg::load_out_type r;
    r.one = (t < one);
    r.full = (t >= full) && (t <= over);
    r.over = (t > over);
    return r;
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [2:0] brk_sync_ff;
  logic [1:0] cur_sync_ff;
  logic [1:0] zs_sync_ff;
  logic [2:0] ctrl_ff;
  logic [15:0] tmr_ff;
  logic [TW-1:0] one_lvl_ff;
  logic [TW-1:0] full_lvl_ff;
  logic [TW-1:0] over_lvl_ff;
  logic [TW-1:0] trq_ff;
  logic [3:0] istat_ff;
  logic [3:0] imask_ff;
  logic [31:0] prdata_ff;
  zsl_pkg::state_type st_ff, nxt_st;
  zsl_pkg::load_out_type outs_ff, nxt_outs;
  logic [31:0] sub_ff, nxt_sub;
  logic [15:0] tick_ff, nxt_tick;
  logic [31:0] dly_ff, nxt_dly;
  logic [3:0] ev;
  zsl_pkg::load_out_type cls;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      brk_sync_ff <= 3'h0;
      cur_sync_ff <= 2'h0;
      zs_sync_ff <= 2'h0;
    end else begin
      brk_sync_ff <= {brk_sync_ff[1:0], BRAKE_RELEASE_INDICATION};
      cur_sync_ff <= {cur_sync_ff[0], MOTOR_CURRENT_ON};
      zs_sync_ff <= {zs_sync_ff[0], ZERO_SPEED};
    end
  end

  wire brk_rise = brk_sync_ff[1] & ~brk_sync_ff[2];
  wire cur_on = cur_sync_ff[1];
  wire zs_on = zs_sync_ff[1];
  wire act_alarm = ctrl_ff[`ZSL_CTRL_ACT];
  wire tv_mode = ctrl_ff[`ZSL_CTRL_TV];
  wire det_en = ctrl_ff[`ZSL_CTRL_EN];

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire setup = PSEL & ~PENABLE;
  wire wr_en = PSEL & PENABLE & PWRITE;
  wire hit_ctrl = (PADDR == `ZSL_OFS_CTRL);
  wire hit_tmr = (PADDR == `ZSL_OFS_TMR);
  wire hit_one = (PADDR == `ZSL_OFS_ONE);
  wire hit_full = (PADDR == `ZSL_OFS_FULL);
  wire hit_over = (PADDR == `ZSL_OFS_OVER);
  wire hit_stat = (PADDR == `ZSL_OFS_STAT);
  wire hit_trq = (PADDR == `ZSL_OFS_TRQ);
  wire hit_istat = (PADDR == `ZSL_OFS_ISTAT);
  wire hit_imask = (PADDR == `ZSL_OFS_IMASK);
  wire addr_ok = hit_ctrl | hit_tmr | hit_one | hit_full | hit_over |
                 hit_stat | hit_trq | hit_istat | hit_imask;
  wire alarm_rst = wr_en & hit_ctrl & PWDATA[`ZSL_CTRL_ARST];
  wire [31:0] stat_word = {19'h0, st_ff, 4'h0, (st_ff == zsl_pkg::ST_ALARM),
                           outs_ff.over, outs_ff.full, outs_ff.one};
  wire [31:0] rd_word =
    hit_ctrl ? {29'h0, ctrl_ff} :
    hit_tmr ? {16'h0, tmr_ff} :
    hit_one ? 32'(one_lvl_ff) :
    hit_full ? 32'(full_lvl_ff) :
    hit_over ? 32'(over_lvl_ff) :
    hit_stat ? stat_word :
    hit_trq ? 32'(trq_ff) :
    hit_istat ? {28'h0, istat_ff} :
    hit_imask ? {28'h0, imask_ff} : 32'h0;

  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~addr_ok;
  assign PRDATA = prdata_ff;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_ff <= `ZSL_CTRL_RST;
      tmr_ff <= `ZSL_TMR_RST;
      one_lvl_ff <= TW'(`ZSL_ONE_RST);
      full_lvl_ff <= TW'(`ZSL_FULL_RST);
      over_lvl_ff <= TW'(`ZSL_OVER_RST);
      imask_ff <= `ZSL_IMASK_RST;
      prdata_ff <= 32'h0;
    end else begin
      if (wr_en & hit_ctrl) ctrl_ff <= PWDATA[2:0];
      if (wr_en & hit_tmr) tmr_ff <= PWDATA[15:0];
      if (wr_en & hit_one) one_lvl_ff <= PWDATA[TW-1:0];
      if (wr_en & hit_full) full_lvl_ff <= PWDATA[TW-1:0];
      if (wr_en & hit_over) over_lvl_ff <= PWDATA[TW-1:0];
      if (wr_en & hit_imask) imask_ff <= PWDATA[3:0];
      if (setup) prdata_ff <= rd_word;
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  wire [3:0] istat_clr = (wr_en & hit_istat) ? PWDATA[3:0] : 4'h0;
  wire [3:0] nxt_istat = (istat_ff & ~istat_clr) | ev;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      istat_ff <= 4'h0;
    end else begin
      istat_ff <= nxt_istat;
    end
  end

  assign IRQ = |(istat_ff & imask_ff);

  // ----------------------------------------
  // Detection sequence
  // ----------------------------------------
  assign cls = classify(MEASURED_TORQUE, one_lvl_ff, full_lvl_ff,
                        over_lvl_ff);
  wire start_ok = det_en & ~tv_mode & zs_on & cur_on;
  wire tick_end = (sub_ff == 32'(TICK_CYC - 1));
  wire expire = (st_ff == zsl_pkg::ST_SETTLE) & (tick_ff >= tmr_ff);
  wire abort = ~zs_on | tv_mode | ~cur_on | ~det_en;
  wire dly_end = (dly_ff == 32'(ALARM_DLY_CYC - 1));

  always_comb begin
    nxt_st = st_ff;
    nxt_outs = outs_ff;
    nxt_sub = 32'h0;
    nxt_tick = 16'h0;
    nxt_dly = 32'h0;
    ev = 4'h0;
    case (st_ff)
      zsl_pkg::ST_IDLE: begin
        // RL3 timer start
        if (brk_rise & start_ok) begin
          nxt_st = zsl_pkg::ST_SETTLE;
        end
      end
      zsl_pkg::ST_SETTLE: begin
        // RL10 RL11 zero speed only
        if (abort) begin
          nxt_st = cur_on ? zsl_pkg::ST_HELD : zsl_pkg::ST_IDLE;
          ev[`ZSL_EV_ABORT] = 1'b1;
        // RL13 restart on rise
        end else if (brk_rise) begin
          nxt_st = zsl_pkg::ST_SETTLE;
        // RL4 RL5 RL6 RL12 single compare
        end else if (expire) begin
          nxt_outs = cls;
          ev[`ZSL_EV_DONE] = 1'b1;
          ev[`ZSL_EV_OVER] = cls.over;
          // RL1 RL2 overload action
          nxt_st = (cls.over & act_alarm) ? zsl_pkg::ST_ALM_WAIT :
                   zsl_pkg::ST_HELD;
        end else begin
          nxt_sub = tick_end ? 32'h0 : sub_ff + 32'h1;
          nxt_tick = tick_end ? tick_ff + 16'h1 : tick_ff;
        end
      end
      zsl_pkg::ST_HELD: begin
        // RL7 RL13 end of travel
        if (~cur_on) begin
          nxt_outs = '0;
          nxt_st = zsl_pkg::ST_IDLE;
        end
      end
      zsl_pkg::ST_ALM_WAIT: begin
        // RL8 brake close delay
        if (dly_end) begin
          nxt_st = zsl_pkg::ST_ALARM;
          ev[`ZSL_EV_ALM] = 1'b1;
        end else begin
          nxt_dly = dly_ff + 32'h1;
        end
      end
      zsl_pkg::ST_ALARM: begin
        // RL7 clear at no current
        if (~cur_on) begin
          nxt_outs = '0;
        end
        if (alarm_rst) begin
          nxt_st = cur_on ? zsl_pkg::ST_HELD : zsl_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_st = zsl_pkg::ST_IDLE;
        nxt_outs = '0;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_ff <= zsl_pkg::ST_IDLE;
      outs_ff <= '0;
      sub_ff <= 32'h0;
      tick_ff <= 16'h0;
      dly_ff <= 32'h0;
      trq_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      outs_ff <= nxt_outs;
      sub_ff <= nxt_sub;
      tick_ff <= nxt_tick;
      dly_ff <= nxt_dly;
      if (expire) trq_ff <= MEASURED_TORQUE;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign ONE_PERSON_LOAD_OUTPUT = outs_ff.one;
  assign FULL_LOAD_OUTPUT = outs_ff.full;
  assign OVERLOAD_OUTPUT = outs_ff.over;
  // RL9 trip actions
  assign OVERLOAD_ALARM = st_ff[4];
  assign CURRENT_STAGE_ENABLE = ~st_ff[4];
  assign BRAKE_APPLY = st_ff[4];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);

  logic [31:0] over_age_ff;
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      over_age_ff <= 32'h0;
    end else begin
      over_age_ff <= outs_ff.over ? over_age_ff + 32'h1 : 32'h0;
    end
  end

  AST_RUN_ON: assert property ( // RL1
    (st_ff == zsl_pkg::ST_SETTLE) && expire && !abort && !brk_rise &&
    cls.over && !act_alarm |=> OVERLOAD_OUTPUT && CURRENT_STAGE_ENABLE &&
    (st_ff == zsl_pkg::ST_HELD))
    else $error("overload in run mode did not hold");
  AST_TRIP_PATH: assert property ( // RL2
    expire && !abort && !brk_rise && cls.over && act_alarm |=>
    OVERLOAD_OUTPUT && (st_ff == zsl_pkg::ST_ALM_WAIT))
    else $error("overload alarm mode not entered");
  AST_TIMER_START: assert property ( // RL3
    (st_ff == zsl_pkg::ST_IDLE) && brk_rise && start_ok |=>
    (st_ff == zsl_pkg::ST_SETTLE) && (tick_ff == 16'h0) && (sub_ff == 32'h0))
    else $error("timer did not start on brake release");
  AST_ONE: assert property ( // RL4
    expire && !abort && !brk_rise && (MEASURED_TORQUE < one_lvl_ff) |=>
    ONE_PERSON_LOAD_OUTPUT && !FULL_LOAD_OUTPUT)
    else $error("one-person output missing");
  AST_FULL: assert property ( // RL5
    expire && !abort && !brk_rise && (MEASURED_TORQUE >= full_lvl_ff) &&
    (MEASURED_TORQUE <= over_lvl_ff) |=> FULL_LOAD_OUTPUT && !OVERLOAD_OUTPUT)
    else $error("full-load output missing");
  AST_OVER: assert property ( // RL6
    expire && !abort && !brk_rise && (MEASURED_TORQUE > over_lvl_ff) |=>
    OVERLOAD_OUTPUT && !FULL_LOAD_OUTPUT)
    else $error("overload output missing");
  AST_HOLD: assert property ( // RL7
    (st_ff == zsl_pkg::ST_HELD) && cur_on |=> $stable(outs_ff))
    else $error("load output changed during travel");
  AST_CLEAR: assert property ( // RL7
    (st_ff == zsl_pkg::ST_HELD) && !cur_on |=> (outs_ff == '0) ##1
    (outs_ff == '0))
    else $error("load output not cleared at end of travel");
  AST_DELAY: assert property ( // RL8
    $rose(OVERLOAD_ALARM) |-> (over_age_ff == 32'(ALARM_DLY_CYC)))
    else $error("overload alarm delay wrong");
  AST_TRIP: assert property ( // RL9
    (st_ff == zsl_pkg::ST_ALM_WAIT) && dly_end |=> !CURRENT_STAGE_ENABLE &&
    BRAKE_APPLY && OVERLOAD_ALARM)
    else $error("alarm did not stop current and apply brake");
  AST_ZERO_SPEED: assert property ( // RL10
    (st_ff == zsl_pkg::ST_SETTLE) && !zs_on |=> (st_ff != zsl_pkg::ST_SETTLE)
    && $stable(outs_ff))
    else $error("detection continued while moving");
  AST_TV_INHIBIT: assert property ( // RL11
    tv_mode && (st_ff != zsl_pkg::ST_SETTLE) |=>
    (st_ff != zsl_pkg::ST_SETTLE))
    else $error("detection ran in torque-vector mode");
  AST_GAP: assert property ( // RL12
    expire && !abort && !brk_rise && (MEASURED_TORQUE >= one_lvl_ff) &&
    (MEASURED_TORQUE < full_lvl_ff) |=> (outs_ff == '0))
    else $error("output raised for torque in gap");
  AST_RESTART: assert property ( // RL13
    (st_ff == zsl_pkg::ST_SETTLE) && brk_rise && !abort |=>
    (tick_ff == 16'h0) && (sub_ff == 32'h0))
    else $error("timer not restarted on new brake release");

endmodule
`default_nettype wire

// [lift_ctrl_model.sv]
`default_nettype none
module lift_ctrl_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [1:0] mode,
  input wire logic [15:0] trq_a,
  input wire logic [15:0] trq_b,
  input wire logic stage_en,
  output logic brake_rel,
  output logic cur_on,
  output logic zspeed,
  output logic [15:0] torque,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  int n;
  // ----------------------------------------
  // One travel per go pulse
  // ----------------------------------------
  initial begin
    brake_rel = 1'b0;
    cur_on = 1'b0;
    zspeed = 1'b1;
    torque = 16'hA5A5;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      if (go) begin
        busy <= 1'b1;
        cur_on <= 1'b1;
        torque <= trq_a;
        repeat (3) @(posedge clk);
        brake_rel <= 1'b1;
        n = 0;
        while (n < 50 && stage_en === 1'b1) begin
          @(posedge clk);
          n++;
          // Mode 2 bounces brake, then shifts torque
          if (mode == 2'd2 && n == 8) brake_rel <= 1'b0;
          if (mode == 2'd2 && n == 10) brake_rel <= 1'b1;
          if (mode == 2'd2 && n == 20) torque <= trq_b;
          // Mode 1 starts moving before expiry
          if (mode == 2'd1 && n == 5) zspeed <= 1'b0;
          if (n == 38) zspeed <= 1'b0;
        end
        brake_rel <= 1'b0;
        zspeed <= 1'b1;
        repeat (2) @(posedge clk);
        // Current gone: torque reading no longer valid
        cur_on <= 1'b0;
        torque <= ~torque;
        repeat (12) @(posedge clk);
        busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [tb_zero_speed_load_detector.sv]
`default_nettype none
module tb_zero_speed_load_detector;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 20000;
  logic core_clk, rst_n, psel, penable, pwrite, go;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, brk_rel, cur_on, zspeed, busy;
  logic alm, cse, brk, irq;
  logic [1:0] mode;
  logic [15:0] trq_a, trq_b, torque;
  wire zsl_pkg::load_out_type lo;
  logic [32:0] rd_q[$];
  logic [14:0] ev_q[$];
  logic [14:0] e;
  logic [6:0] cur;
  logic [6:0] prv = 7'h0;
  logic [31:0] w;
  int cyc, lastc, checks, n_mismatch, seed;
  logic [7:0] ra[9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C,
    8'h20, 8'h24};
  logic [32:0] rv[9] = '{33'h4, 33'h64, 33'h1000, 33'h6000, 33'h7000,
    33'h100, 33'h0, 33'h0, 33'h1_0000_0000};
  logic [15:0] tq[7] = '{16'h0800, 16'h0FFF, 16'h1000, 16'h5FFF, 16'h6000,
    16'h7000, 16'h7001};

  zero_speed_load_detector #(.TICK_CYC(4), .ALARM_DLY_CYC(20)) dut (
    .CORE_CLK(core_clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready),
    .PSLVERR(pslverr), .PRDATA(prdata), .BRAKE_RELEASE_INDICATION(brk_rel),
    .MOTOR_CURRENT_ON(cur_on), .ZERO_SPEED(zspeed),
    .MEASURED_TORQUE(torque), .ONE_PERSON_LOAD_OUTPUT(lo.one),
    .FULL_LOAD_OUTPUT(lo.full), .OVERLOAD_OUTPUT(lo.over),
    .OVERLOAD_ALARM(alm), .CURRENT_STAGE_ENABLE(cse), .BRAKE_APPLY(brk),
    .IRQ(irq));

  lift_ctrl_model lift (.clk(core_clk), .go(go), .mode(mode),
    .trq_a(trq_a), .trq_b(trq_b), .stage_en(cse), .brake_rel(brk_rel),
    .cur_on(cur_on), .zspeed(zspeed), .torque(torque), .busy(busy));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // Compare and report
  // ----------------------------------------
  task automatic cmp_rd(input logic [32:0] x, input logic [32:0] g);
    checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("wrong value at %0t: exp %h got %h", $time, x, g);
    end
  endtask

  task automatic cmp_ev(input logic [14:0] x, input logic [6:0] g, int d);
    checks++;
    if (g !== x[6:0] || (x[14:7] != 0 && d != int'(x[14:7]))) begin
      n_mismatch++;
      $display("wrong value at %0t: exp %h got %h", $time, x, {d[7:0], g});
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Output monitor
  // ----------------------------------------
  always @(posedge core_clk) begin
    cyc++;
    cur = {irq, ~cse, brk, alm, lo.over, lo.full, lo.one};
    if (cur !== prv) begin
      e = (ev_q.size() > 0) ? ev_q.pop_front() : {8'hFF, ~cur};
      cmp_ev(e, cur, cyc - lastc);
      prv = cur;
      lastc = cyc;
    end
    if (psel && penable && !pwrite && pready === 1'b1) begin
      if (rd_q.size() > 0) begin
        cmp_rd(rd_q.pop_front(), {pslverr, prdata});
      end else begin
        cmp_rd(33'h0, 33'hX);
      end
    end
  end

  initial begin
    repeat (LIMIT) @(posedge core_clk);
    n_mismatch++;
    $display("timeout");
    final_report();
  end

  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] x);
    rd_q.push_back(x);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic travel(input logic [1:0] m, logic [15:0] ta, logic [15:0] tb);
    @(posedge core_clk);
    mode <= m;
    trq_a <= ta;
    trq_b <= tb;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    @(posedge core_clk);
    while (busy) @(posedge core_clk);
  endtask

  function automatic logic [6:0] cls(input logic [15:0] t);
    if (t < 16'h1000) return 7'h01;
    if (t < 16'h6000) return 7'h00;
    if (t <= 16'h7000) return 7'h02;
    return 7'h04;
  endfunction

  task automatic run_load(input logic [15:0] t);
    logic [6:0] c;
    c = cls(t);
    if (c != 0) ev_q.push_back({8'h0, c});
    if (c != 0) ev_q.push_back(15'h0);
    travel(2'd0, t, t);
    rd(8'h18, {17'h0, t});
    rd(8'h1C, {31'h0, c[2], 1'b1});
    apb(1'b1, 8'h1C, 32'hF);
    $display("test load %h done", t);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    go = 1'b0;
    mode = 2'd0;
    trq_a = 16'h0;
    trq_b = 16'h0;
    seed = 61885;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (ra[i]) rd(ra[i], rv[i]);
    apb(1'b1, 8'h14, 32'hFFFF);
    rd(8'h14, 33'h100);
    for (int i = 1; i < 5; i++) begin
      w = $random(seed);
      apb(1'b1, ra[i], w);
      rd(ra[i], {17'h0, w[15:0]});
      apb(1'b1, ra[i], rv[i][31:0]);
    end
    $display("test registers done");
    apb(1'b1, 8'h04, 32'h3);
    foreach (tq[i]) run_load(tq[i]);
    repeat (3) run_load(16'($random(seed)));
    apb(1'b1, 8'h00, 32'h6);
    travel(2'd0, 16'h0800, 16'h0800);
    rd(8'h1C, 33'h0);
    apb(1'b1, 8'h00, 32'h0);
    travel(2'd0, 16'h0800, 16'h0800);
    rd(8'h1C, 33'h0);
    apb(1'b1, 8'h00, 32'h4);
    $display("test vector mode done");
    apb(1'b1, 8'h20, 32'h8);
    ev_q.push_back(15'h40);
    travel(2'd1, 16'h0800, 16'h0800);
    rd(8'h1C, 33'h8);
    ev_q.push_back(15'h0);
    apb(1'b1, 8'h20, 32'h0);
    ev_q.push_back(15'h40);
    apb(1'b1, 8'h20, 32'h8);
    ev_q.push_back(15'h0);
    apb(1'b1, 8'h1C, 32'h8);
    apb(1'b1, 8'h20, 32'h0);
    $display("test abort irq done");
    ev_q.push_back(15'h02);
    ev_q.push_back(15'h0);
    travel(2'd2, 16'h0800, {4'h6, 12'($random(seed))});
    $display("test restart done");
    apb(1'b1, 8'h00, 32'h5);
    ev_q.push_back(15'h04);
    ev_q.push_back({8'd20, 7'h3C});
    ev_q.push_back(15'h38);
    travel(2'd0, {1'b1, 15'($random(seed))}, 16'h7800);
    ev_q.push_back(15'h0);
    apb(1'b1, 8'h00, 32'hD);
    apb(1'b1, 8'h00, 32'h4);
    $display("test alarm done");
    repeat (10) @(posedge core_clk);
    if (ev_q.size() != 0 || rd_q.size() != 0) begin
      n_mismatch++;
      $display("missing results");
    end
    final_report();
  end
endmodule
`default_nettype wire
